// ===== hw/cfg_port_pkg.sv
package cfg_port_pkg;
    // ==================================================
    // Mode encodings of the two mode-select inputs
    localparam logic [1:0] MODE_SPI_SLAVE = 2'h0;   // Host drives serial clock
    localparam logic [1:0] MODE_SPI_MASTER = 2'h1;  // Device reads external flash
    localparam logic [1:0] MODE_RESERVED_A = 2'h2;  // No serial port role
    localparam logic [1:0] MODE_RESERVED_B = 2'h3;  // No serial port role
    localparam logic [1:0] MODE_RESET = 2'h0;       // Captured mode after reset

    // ==================================================
    // Timing counts
    localparam int CLK_PERIOD_NS = 5;               // System clock period
    localparam int INIT_HOLD_NS = 100;              // Least time ready line held low
    localparam int INIT_HOLD_CYC = (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] MASTER_DIV_HALF = 8'h04; // Master clock half period, cycles
    localparam int WORD_BITS = 8;                   // Bits per configuration byte
    localparam logic [31:0] DEFAULT_BYTES = 32'h0000_0010; // Default image length

    // ==================================================
    // Port selection state
    typedef enum logic [1:0] {
        PORT_NONE,
        PORT_SERIAL,
        PORT_TEST
    } port_sel_t;

    // Tristate pin pair
    typedef struct packed {
        logic o;   // Driven level
        logic oe;  // High while driving
    } od_drive_t;

    // Serial port pin drives as a group
    typedef struct packed {
        od_drive_t sclk;    // Serial clock drive
        od_drive_t data_a;  // First data pin drive
        od_drive_t data_b;  // Second data pin drive
        od_drive_t fsel;    // Flash select drive
    } spi_drive_t;
endpackage : cfg_port_pkg

// ===== hw/fpga_config_port_control.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Mode pins captured at ready line rising
// - Open-drain ready line released when ready
// - Low program request starts configuration
// - Completion line released when configuration done
// - Serial clock pin bidirectional, times transfer
// - Data pin A: slave input, master output
// - Data pin B: slave output, master input
// - Master mode drives flash select
// - Test port may claim configuration after power-up
// - First chosen port locked until power-up
// - Output enable low tristates user I/O and serial pins; ready and completion lines unaffected
// - User I/O tristated, pulled up during configuration
module fpga_config_port_control #(
    parameter int NUM_IO = 8,                                // User I/O count
    parameter logic [31:0] IMAGE_BYTES = cfg_port_pkg::DEFAULT_BYTES // Bytes per image
) (
    input wire logic clk_in,                                 // 200 MHz system clock
    input wire logic nrst_in,                                // Power-up reset, active low
    input wire logic [1:0] mode_sel_in,                      // Mode select pins
    input wire logic program_request_n_in,                   // Program request pin
    input wire logic init_ready_n_in,                        // Ready line pin level
    output logic init_ready_n_o_out,                         // Ready line drive level
    output logic init_ready_n_oe_out,                        // Ready line drive enable
    input wire logic done_in,                                // Completion line pin level
    output logic done_o_out,                                 // Completion drive level
    output logic done_oe_out,                                // Completion drive enable
    input wire logic config_serial_clock_in,                 // Serial clock pin level
    input wire logic spi_data_pin_a_in,                      // Data pin A level
    input wire logic spi_data_pin_b_in,                      // Data pin B level
    input wire logic slave_select_n_in,                      // Slave select pin
    output cfg_port_pkg::spi_drive_t spi_drive_out,          // Serial pin drives
    input wire logic test_config_cmd_in,                     // Test port config command
    input wire logic [7:0] test_data_in,                     // Test port data byte
    input wire logic test_data_valid_in,                     // Test port byte strobe
    input wire logic io_output_enable_n_in,                  // Global output enable pin
    input wire logic [NUM_IO-1:0] user_io_o_in,              // User output levels
    input wire logic [NUM_IO-1:0] user_io_oe_in,             // User output enables
    output logic [NUM_IO-1:0] user_io_o_out,                 // I/O drive levels
    output logic [NUM_IO-1:0] user_io_oe_out,                // I/O drive enables
    output logic [NUM_IO-1:0] user_io_pullup_out,            // I/O pull-up enables
    output logic [1:0] config_mode_out,                      // Captured mode
    output cfg_port_pkg::port_sel_t port_sel_out,            // Locked port
    output logic [7:0] config_byte_out,                      // Last byte loaded
    output logic config_byte_valid_out,                      // Byte strobe
    output logic configuring_out                             // Configuration in progress
);
    import cfg_port_pkg::*;

    // ==================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_CLEAR,     // Ready line held low
        ST_WAIT,      // Ready, awaiting data
        ST_LOAD,      // Bytes arriving
        ST_DONE       // Startup under way
    } seq_t;

    seq_t state;                    // Current sequencer state
    seq_t next_state;               // Next sequencer state
    logic [7:0] hold_cnt;           // Ready-low hold counter
    logic [31:0] byte_cnt;          // Bytes loaded
    logic [1:0] mode;               // Captured mode
    port_sel_t port_sel;            // Locked port choice
    logic [7:0] byte_q;             // Byte output register
    logic byte_v;                   // Byte strobe register

    // ==================================================
    // Two-flop synchronisers for pins
    logic [1:0] prog_s, init_s, toe_s, ssel_s, datb_s, tcmd_s;
    logic [1:0] mode_s0, mode_s1;   // Mode pin stages
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_s <= 2'h3;
            init_s <= 2'h0;
            toe_s <= 2'h3;
            ssel_s <= 2'h3;
            datb_s <= 2'h0;
            tcmd_s <= 2'h0;
            mode_s0 <= 2'h0;
            mode_s1 <= 2'h0;
        end else begin
            prog_s <= {prog_s[0], program_request_n_in};
            init_s <= {init_s[0], init_ready_n_in};
            toe_s <= {toe_s[0], io_output_enable_n_in};
            ssel_s <= {ssel_s[0], slave_select_n_in};
            datb_s <= {datb_s[0], spi_data_pin_b_in};
            tcmd_s <= {tcmd_s[0], test_config_cmd_in};
            mode_s0 <= mode_sel_in;
            mode_s1 <= mode_s0;
        end
    end

    // Synced pin levels
    wire prog_req = !prog_s[1];                 // Program requested
    wire ssel_n = ssel_s[1];                    // Synced slave select
    wire init_lvl = init_s[1];                  // Synced ready line
    wire toe_n = toe_s[1];                      // Synced output enable
    wire done_lvl_unused = done_in;             // Line read back only by the bench

    // Edge detect on the synced ready line, one stage past the pair
    logic init_d;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) init_d <= 1'b0;
        else init_d <= init_lvl;
    end
    wire init_rise = init_lvl && !init_d;

    // ==================================================
    // Mode capture, changed only on the ready line rising
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) mode <= MODE_RESET;
        else if (init_rise) mode <= mode_s1;
    end
    assign config_mode_out = mode;
    wire is_master = (mode == MODE_SPI_MASTER);
    wire is_slave = (mode == MODE_SPI_SLAVE);

    // ==================================================
    // Slave receiver on the host clock, byte crossed by toggle
    logic [7:0] rx_word;
    logic rx_tgl;
    spi_link_rx u_rx (
        .link_clk_in(config_serial_clock_in),
        .nrst_in(nrst_in),
        .sel_n_in(slave_select_n_in),
        .data_in(spi_data_pin_a_in),
        .word_out(rx_word),
        .word_tgl_out(rx_tgl)
    );

    // Toggle crossing; host word holds meanwhile
    logic [2:0] tgl_s;                          // Toggle sync plus edge stage
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) tgl_s <= 3'h0;
        else tgl_s <= {tgl_s[1:0], rx_tgl};
    end
    wire slave_byte = tgl_s[2] ^ tgl_s[1];      // Word stable by now

    // ==================================================
    // Master clock generator and receiver, clocked from system clock
    logic [7:0] div;                            // Half period counter
    logic mclk;                                 // Generated serial clock
    logic [7:0] msh;                            // Master shift register
    logic [2:0] mcnt;                           // Master bit count
    logic mbyte;                                // Master byte strobe
    // Clock only while loading from flash
    wire master_run = (state == ST_LOAD) && is_master && (port_sel == PORT_SERIAL);
    wire div_end = (div == MASTER_DIV_HALF - 8'h01);
    wire mrise = master_run && div_end && !mclk;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div <= 8'h00;
            mclk <= 1'b0;
            msh <= 8'h00;
            mcnt <= 3'h0;
            mbyte <= 1'b0;
        end else begin
            mbyte <= 1'b0;
            if (!master_run) begin
                div <= 8'h00;
                mclk <= 1'b0;
                mcnt <= 3'h0;
            end else if (div_end) begin
                div <= 8'h00;
                mclk <= ~mclk;
                if (mrise) begin
                    msh <= {msh[6:0], datb_s[1]};
                    mcnt <= mcnt + 3'h1;
                    mbyte <= (mcnt == 3'h7);
                end
            end else begin
                div <= div + 8'h01;
            end
        end
    end

    // ==================================================
    // Port lock: first claim wins until power-up reset
    wire serial_claim = (state == ST_WAIT) && (is_master || (is_slave && slave_byte));
    wire test_claim = tcmd_s[1];
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) port_sel <= PORT_NONE;
        else if (port_sel == PORT_NONE) begin
            if (test_claim) port_sel <= PORT_TEST;
            else if (serial_claim) port_sel <= PORT_SERIAL;
        end
    end
    assign port_sel_out = port_sel;

    // Byte source follows the locked port only
    wire [7:0] src_byte = (port_sel == PORT_TEST) ? test_data_in :
                          is_master ? msh : rx_word;
    wire src_valid = (port_sel == PORT_TEST) ? test_data_valid_in :
                     (port_sel == PORT_SERIAL) ? (is_master ? mbyte : slave_byte) : 1'b0;
    wire last_byte = (byte_cnt == IMAGE_BYTES - 32'h1) && src_valid;

    // ==================================================
    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            ST_CLEAR: if (hold_cnt == 8'(INIT_HOLD_CYC)) next_state = ST_WAIT;
            ST_WAIT: if (port_sel != PORT_NONE) next_state = ST_LOAD;
            ST_LOAD: if (last_byte) next_state = ST_DONE;
            ST_DONE: next_state = ST_DONE;
            default: next_state = ST_CLEAR;
        endcase
        if (prog_req) next_state = ST_CLEAR;
    end

    // Sequencer registers and byte capture
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_CLEAR;
            hold_cnt <= 8'h00;
            byte_cnt <= 32'h0;
            byte_q <= 8'h00;
            byte_v <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= (state == ST_CLEAR && !prog_req) ? hold_cnt + 8'h01 : 8'h00;
            byte_v <= (state == ST_LOAD) && src_valid;
            if ((state == ST_LOAD) && src_valid) begin
                byte_q <= src_byte;
                byte_cnt <= byte_cnt + 32'h1;
            end
            if (state == ST_CLEAR) byte_cnt <= 32'h0;
        end
    end
    assign config_byte_out = byte_q;
    assign config_byte_valid_out = byte_v;
    assign configuring_out = (state != ST_DONE);

    // ==================================================
    // Open-drain lines: drive low or release
    assign init_ready_n_o_out = 1'b0;
    assign init_ready_n_oe_out = (state == ST_CLEAR);
    assign done_o_out = 1'b0;
    assign done_oe_out = (state != ST_DONE);

    // ==================================================
    // Serial pin drives; test clock quietness is the system's duty
    wire ser_active = configuring_out && (port_sel != PORT_TEST) && toe_n;

    // Slave output follows the synced select
    always_comb begin
        spi_drive_out = '0;
        if (ser_active && is_master) begin
            spi_drive_out.sclk = '{o: mclk, oe: 1'b1};
            spi_drive_out.data_a = '{o: 1'b0, oe: 1'b1};
            spi_drive_out.fsel = '{o: !master_run, oe: 1'b1};
        end else if (ser_active && is_slave && !ssel_n) begin
            spi_drive_out.data_b = '{o: init_lvl, oe: 1'b1};
        end
    end

    // ==================================================
    // User I/O: tristate during configuration or output disable, pull-up during configuration only
    wire io_off = configuring_out || !toe_n;
    assign user_io_o_out = user_io_o_in;
    assign user_io_oe_out = io_off ? '0 : user_io_oe_in;
    assign user_io_pullup_out = configuring_out ? '1 : '0;

    // ==================================================
    // Checks
    // Named step: a synced request
    sequence s_prog;
        prog_req;
    endsequence

    // Request forces the clear phase
    property p_prog_clear;
        @(posedge clk_in) disable iff (!nrst_in) s_prog |=> (state == ST_CLEAR);
    endproperty
    a_prog_clear: assert property (p_prog_clear) else $error("no restart");

    // Mode moves only at a capture
    property p_mode_hold;
        @(posedge clk_in) disable iff (!nrst_in) !init_rise |=> $stable(mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");

    // Capture takes the synced pins
    property p_mode_cap;
        @(posedge clk_in) disable iff (!nrst_in) init_rise |=> (mode == $past(mode_s1));
    endproperty
    a_mode_cap: assert property (p_mode_cap) else $error("mode miss");

    // Lock never lets go
    property p_lock;
        @(posedge clk_in) disable iff (!nrst_in)
            (port_sel != PORT_NONE) |=> $stable(port_sel);
    endproperty
    a_lock: assert property (p_lock) else $error("port changed");

    // Output enable pin wins
    property p_toe;
        @(posedge clk_in) disable iff (!nrst_in) !toe_n |-> (user_io_oe_out == '0);
    endproperty
    a_toe: assert property (p_toe) else $error("io driven");

    // I/O parked while loading
    property p_cfg_io;
        @(posedge clk_in) disable iff (!nrst_in)
            configuring_out |-> (user_io_oe_out == '0) && (user_io_pullup_out == '1);
    endproperty
    a_cfg_io: assert property (p_cfg_io) else $error("io not off");

    // Last byte ends configuration
    property p_done;
        @(posedge clk_in) disable iff (!nrst_in)
            (state == ST_LOAD) && last_byte && !prog_req |=> !done_oe_out;
    endproperty
    a_done: assert property (p_done) else $error("done held");

    // Clear phase holds ready low
    property p_init;
        @(posedge clk_in) disable iff (!nrst_in)
            $rose(state == ST_CLEAR) |-> init_ready_n_oe_out [*2];
    endproperty
    a_init: assert property (p_init) else $error("ready early");

    // Flash kept selected while reading
    property p_fsel;
        @(posedge clk_in) disable iff (!nrst_in)
            master_run && toe_n |-> spi_drive_out.fsel.oe && !spi_drive_out.fsel.o;
    endproperty
    a_fsel: assert property (p_fsel) else $error("flash unselected");

    // Slave mode never drives host data
    property p_slave_a;
        @(posedge clk_in) disable iff (!nrst_in) is_slave |-> !spi_drive_out.data_a.oe;
    endproperty
    a_slave_a: assert property (p_slave_a) else $error("data a driven");
endmodule : fpga_config_port_control
`default_nettype wire

// ===== hw/spi_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Slave serial receiver on the host serial clock
module spi_link_rx (
    input wire logic link_clk_in,       // Host serial clock
    input wire logic nrst_in,           // Async reset, active low
    input wire logic sel_n_in,          // Slave select, active low
    input wire logic data_in,           // Serial data from host
    output logic [7:0] word_out,        // Last full byte
    output logic word_tgl_out           // Toggles per full byte
);
    import cfg_port_pkg::*;

    logic [7:0] shift;   // Incoming bits
    logic [2:0] count;   // Bits collected in this byte
    wire [7:0] next_shift = {shift[6:0], data_in};
    wire last_bit = (count == 3'h7);

    // ==================================================
    // Shift on rising clock while framed; select high restarts the byte
    always_ff @(posedge link_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift <= 8'h00;
            word_out <= 8'h00;
            word_tgl_out <= 1'b0;
        end else if (!sel_n_in) begin
            shift <= next_shift;
            if (last_bit) begin
                word_out <= next_shift;        // Held stable across toggle crossing
                word_tgl_out <= ~word_tgl_out;
            end
        end
    end

    // Count cleared while deselected: host may stop its clock mid-byte
    wire cnt_clr_n = nrst_in && !sel_n_in;     // Reset or frame end
    always_ff @(posedge link_clk_in or negedge cnt_clr_n) begin
        if (!cnt_clr_n) count <= 3'h0;
        else count <= count + 3'h1;
    end
endmodule : spi_link_rx
`default_nettype wire

// ===== verification/cfg_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Serial flash holding a short image, read from offset zero
module cfg_flash_model (
    input wire logic sclk_in,  // Serial clock from device
    input wire logic sel_n_in, // Flash select, active low
    output logic data_out      // Serial data to device
);
    logic [7:0] image [0:3]; // Image bytes, MSB first
    int bit_idx;             // Bit position in image
    initial begin
        image = '{8'ha5, 8'h3c, 8'h96, 8'h0f};
        data_out = 1'b0;
        bit_idx = 0;
    end
    // First bit present as soon as selected
    always @(negedge sel_n_in) begin
        bit_idx = 0;
        data_out = image[0][7];
    end
    // Shift on falling edge so the rising edge sees settled data
    always @(negedge sclk_in) begin
        if (!sel_n_in) begin
            bit_idx = bit_idx + 1;
            data_out = image[(bit_idx / 8) % 4][7 - (bit_idx % 8)];
        end
    end
    // Released line must not keep a stale bit
    always @(posedge sel_n_in) begin
        data_out = ~data_out;
    end
endmodule : cfg_flash_model
`default_nettype wire

// ===== verification/fpga_config_port_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fpga_config_port_control_bench;
    import cfg_port_pkg::*;
    // ==================================================
    // Stimulus, outputs and wires
    typedef struct packed {
        logic [1:0] mode;
        logic fsel_oe;
        logic a_oe;
        port_sel_t port;
    } mode_row_t;
    mode_row_t rows [4] = '{'{MODE_SPI_SLAVE, 1'b0, 1'b0, PORT_NONE},
        '{MODE_SPI_MASTER, 1'b1, 1'b1, PORT_SERIAL},
        '{MODE_RESERVED_A, 1'b0, 1'b0, PORT_NONE},
        '{MODE_RESERVED_B, 1'b0, 1'b0, PORT_NONE}};
    logic clk_in, nrst_in, prog_n, toe_n, host_sclk, host_mosi, host_sel_n;
    logic test_cmd, test_valid, ready_o, ready_oe, done_o, done_oe;
    logic cvalid, configuring, flash_do;
    logic [1:0] mode_sel, cfg_mode;
    logic [7:0] test_data, user_o, user_oe, io_o, io_oe, io_pu, cbyte;
    spi_drive_t drv;
    port_sel_t port;
    wire logic ready_w, done_w, sclk_w, a_w, b_w, fsel_w;
    int fail_count = 0;
    int compares = 0;
    logic [7:0] got_q [$]; // Bytes the device loaded
    // Open-drain lines pulled up; shared pins resolved from enables
    assign ready_w = (ready_oe && !ready_o) ? 1'b0 : 1'b1;
    assign done_w = (done_oe && !done_o) ? 1'b0 : 1'b1;
    assign sclk_w = drv.sclk.oe ? drv.sclk.o : host_sclk;
    assign a_w = drv.data_a.oe ? drv.data_a.o : host_mosi;
    assign b_w = drv.data_b.oe ? drv.data_b.o : flash_do;
    assign fsel_w = drv.fsel.oe ? drv.fsel.o : 1'b1;
    cfg_flash_model u_flash (.sclk_in(sclk_w), .sel_n_in(fsel_w), .data_out(flash_do));
    fpga_config_port_control #(.IMAGE_BYTES(32'h0000_0002)) u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .mode_sel_in(mode_sel),
        .program_request_n_in(prog_n), .init_ready_n_in(ready_w),
        .init_ready_n_o_out(ready_o), .init_ready_n_oe_out(ready_oe),
        .done_in(done_w), .done_o_out(done_o), .done_oe_out(done_oe),
        .config_serial_clock_in(sclk_w), .spi_data_pin_a_in(a_w),
        .spi_data_pin_b_in(b_w), .slave_select_n_in(host_sel_n),
        .spi_drive_out(drv), .test_config_cmd_in(test_cmd), .test_data_in(test_data),
        .test_data_valid_in(test_valid), .io_output_enable_n_in(toe_n),
        .user_io_o_in(user_o), .user_io_oe_in(user_oe), .user_io_o_out(io_o),
        .user_io_oe_out(io_oe), .user_io_pullup_out(io_pu), .config_mode_out(cfg_mode),
        .port_sel_out(port), .config_byte_out(cbyte), .config_byte_valid_out(cvalid),
        .configuring_out(configuring)
    );
    // ==================================================
    // Clock, byte monitor and watchdog
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    always @(negedge clk_in) begin
        if (cvalid === 1'b1) got_q.push_back(cbyte);
    end
    // Whole run is well under 30 us
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    // ==================================================
    // Compare and drive tasks
    task automatic check1(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", name, e, g);
        end
    endtask : check1
    task automatic check8(input string name, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : check8
    task automatic check_bytes(input logic [7:0] e0, input logic [7:0] e1);
        check8("byte_count", 8'h02, 8'(got_q.size()));
        if (got_q.size() == 2) begin
            check8("byte0", e0, got_q[0]);
            check8("byte1", e1, got_q[1]);
        end
    endtask : check_bytes
    task automatic power_up(input logic [1:0] m);
        @(negedge clk_in);
        nrst_in = 1'b0;
        mode_sel = m; // Stable long before the ready line rises
        repeat (16) @(negedge clk_in);
        nrst_in = 1'b1;
        got_q.delete();
        repeat (10) @(negedge clk_in);
        check1("ready_hold", 1'b0, ready_w);
    endtask : power_up
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready_w !== 1'b1 && n < 400) begin
            @(negedge clk_in);
            n++;
        end
        check1("ready_release", 1'b1, ready_w);
        repeat (6) @(negedge clk_in);
    endtask : wait_ready
    task automatic wait_done;
        int n;
        n = 0;
        while (done_oe !== 1'b0 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        check1("done_release", 1'b0, done_oe);
        check1("configuring_end", 1'b0, configuring);
        @(negedge clk_in);
    endtask : wait_done
    // Host byte on the link clock, MSB first; clock still between bytes
    task automatic host_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            host_mosi = b[i];
            #12 host_sclk = 1'b1;
            #24 host_sclk = 1'b0;
            #12;
        end
    endtask : host_byte
    task automatic pulse_test(input logic [7:0] b);
        @(negedge clk_in);
        test_data = b;
        test_valid = 1'b1;
        @(negedge clk_in);
        test_valid = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask : pulse_test
    task automatic end_sim;
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // ==================================================
    // Main sequence
    initial begin
        {nrst_in, host_sclk, host_mosi, test_valid} = 4'h0;
        {prog_n, toe_n, host_sel_n} = 3'h7;
        test_cmd = 1'b0;
        mode_sel = 2'h0;
        test_data = 8'h00;
        user_o = 8'h5a;
        user_oe = 8'hff;
        repeat (4) @(negedge clk_in);
        check1("ready_oe_rst", 1'b1, ready_oe);
        check1("done_oe_rst", 1'b1, done_oe);
        check8("pullup_rst", 8'hff, io_pu);
        // Every mode: capture, pin roles, lock; master runs to completion
        foreach (rows[k]) begin
            power_up(rows[k].mode);
            wait_ready();
            check8("mode", {6'h0, rows[k].mode}, {6'h0, cfg_mode});
            check1("fsel_oe", rows[k].fsel_oe, drv.fsel.oe);
            check1("data_a_oe", rows[k].a_oe, drv.data_a.oe);
            check8("port", {6'h0, rows[k].port}, {6'h0, port});
            check8("io_oe_cfg", 8'h00, io_oe);
            check8("pullup_cfg", 8'hff, io_pu);
            if (rows[k].mode == MODE_SPI_MASTER) begin
                check1("fsel_level", 1'b0, fsel_w);
                check1("data_b_oe", 1'b0, drv.data_b.oe);
                wait_done();
                check_bytes(8'ha5, 8'h3c);
            end
        end
        // Slave load: claim byte then image; test port then refused
        power_up(MODE_SPI_SLAVE);
        wait_ready();
        host_sel_n = 1'b0;
        host_byte(8'h5a);
        check1("data_b_oe_slave", 1'b1, drv.data_b.oe);
        @(negedge clk_in);
        toe_n = 1'b0;
        repeat (4) @(negedge clk_in);
        check1("data_b_oe_toe", 1'b0, drv.data_b.oe);
        toe_n = 1'b1;
        repeat (4) @(negedge clk_in);
        host_byte(8'hc3);
        host_byte(8'h81);
        @(negedge clk_in);
        host_sel_n = 1'b1;
        wait_done();
        check_bytes(8'hc3, 8'h81);
        test_cmd = 1'b1;
        pulse_test(8'h77);
        repeat (6) @(negedge clk_in);
        check8("port_lock", {6'h0, PORT_SERIAL}, {6'h0, port});
        check_bytes(8'hc3, 8'h81);
        // Output enable pin overrides user I/O; serial pin drivers already off once configuration is done
        repeat (20) @(negedge clk_in);
        check8("io_oe_user", 8'hff, io_oe);
        check8("io_o_user", 8'h5a, io_o);
        toe_n = 1'b0;
        repeat (4) @(negedge clk_in);
        check8("io_oe_toe", 8'h00, io_oe);
        check8("spi_oe_toe", 8'h00, {4'h0, drv.sclk.oe, drv.data_a.oe,
            drv.data_b.oe, drv.fsel.oe});
        toe_n = 1'b1;
        test_cmd = 1'b0;
        // Program request restarts; mode held until the next capture
        @(negedge clk_in);
        prog_n = 1'b0;
        mode_sel = MODE_RESERVED_A;
        repeat (6) @(negedge clk_in);
        check1("ready_oe_prog", 1'b1, ready_oe);
        check1("done_oe_prog", 1'b1, done_oe);
        check8("mode_held", 8'h00, {6'h0, cfg_mode});
        prog_n = 1'b1;
        wait_ready();
        check8("mode_recap", {6'h0, MODE_RESERVED_A}, {6'h0, cfg_mode});
        check8("port_kept", {6'h0, PORT_SERIAL}, {6'h0, port});
        // Test port claims first; a later serial frame is ignored
        power_up(MODE_RESERVED_A);
        wait_ready();
        test_cmd = 1'b1;
        repeat (5) @(negedge clk_in);
        check8("port_test", {6'h0, PORT_TEST}, {6'h0, port});
        pulse_test(8'h11);
        pulse_test(8'h22);
        wait_done();
        check_bytes(8'h11, 8'h22);
        host_sel_n = 1'b0;
        host_byte(8'h5a);
        host_byte(8'h66);
        @(negedge clk_in);
        host_sel_n = 1'b1;
        repeat (6) @(negedge clk_in);
        check8("port_test_lock", {6'h0, PORT_TEST}, {6'h0, port});
        check_bytes(8'h11, 8'h22);
        end_sim();
    end
endmodule : fpga_config_port_control_bench
`default_nettype wire
